// ### include/bth_map.svh
`ifndef BTH_MAP_SVH
`define BTH_MAP_SVH

// Register byte offsets on the AHB-Lite slave.
`define BTH_CTRL_OFS      4'h0
`define BTH_STATUS_OFS    4'h4
`define BTH_ATTEMPT_OFS   4'h8

// Control register fields.
`define BTH_CTRL_SERR_EN  0
`define BTH_CTRL_MA_MODE  1
`define BTH_CTRL_DIS_DW   2
`define BTH_CTRL_DIS_PW   3
`define BTH_CTRL_DIS_DR   4
`define BTH_CTRL_RESET    5'h00

// Status register fields, write one to clear.
`define BTH_ST_RCV_TA_PRI 0
`define BTH_ST_RCV_TA_SEC 1
`define BTH_ST_SIG_TA_PRI 2
`define BTH_ST_SIG_TA_SEC 3
`define BTH_ST_SIG_SERR   4
`define BTH_STATUS_RESET  5'h00

// Retry limit, room needed for a posted write, master-abort wait.
`define BTH_ATTEMPT_LIMIT 25'h1000000
`define BTH_PW_MIN_DW     5'h08
`define BTH_DEVSEL_WAIT   3'h5

`endif

// ### include/bth_pkg.sv
package bth_pkg;

  typedef enum logic [1:0] {KIND_DW, KIND_PW, KIND_DR} kind_type;
  typedef enum logic [2:0] {T_NORMAL, T_RETRY, T_DISC, T_TABORT, T_MABORT} term_type;
  typedef enum logic [1:0] {R_TRDY, R_RETRY, R_DISC, R_TABORT} resp_type;
  typedef enum logic [1:0] {S_IDLE, S_ACTIVE, S_DONE, S_EXHAUSTED} fsm_type;

  // Transaction being forwarded to the target bus.
  typedef struct packed {
    kind_type    kind;
    logic        multi;
    logic        prefetch;
    logic        mwi;
    logic [31:0] addr;
  } txn_type;

  // Termination seen on the target bus at the end of one attempt.
  typedef struct packed {
    logic       valid;
    term_type   code;
    logic       xfer;
    logic [7:0] dwords;
    logic       more_req;
  } term_in_type;

  // Queue and buffer conditions on the initiator side.
  typedef struct packed {
    logic       queuing;
    logic       pending;
    logic       not_head;
    logic       q_full;
    logic       dup;
    logic       pw_ahead;
    logic       discarding;
    logic [4:0] pw_space;
    logic       boundary;
    logic       no_space;
    logic       no_read;
  } cond_type;

  typedef struct packed {
    logic     valid;
    resp_type code;
  } resp_out_type;

  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
    logic        plain_write;
  } reissue_type;

endpackage : bth_pkg

// ### logic/bth_term_handler.sv
`timescale 1ns/1ps
`include "bth_map.svh"
// Overview of operation
// - Delayed write ended normally or disconnected: disconnect initiator if multi-phase.
// - Delayed write retried: retry initiator and keep re-attempting.
// - Delayed write target abort: abort initiator, set received and signaled flags.
// - Repeat delayed write until data moves, an abort, or limit retries.
// - Delayed write limit reached: conditional system error, discard, abort next attempt.
// - Posted write: nothing on normal, repeat on retry, continue after disconnect.
// - Posted write target abort: received flag, conditional system error and flag.
// - Re-attempt uses original address after retry, advanced address after disconnect.
// - Partly delivered memory write and invalidate continues as plain memory write.
// - Posted write limit reached: discard data, conditional system error.
// - Delayed read normal: disconnect non-prefetchable; prefetchable only if more wanted.
// - Delayed read retried is repeated; disconnect relayed when more was wanted.
// - Delayed read target abort: abort initiator, set received and signaled flags.
// - Delayed read repeats until progress or limit; then error, discard, abort.
// - Retry delayed write initiator while queuing, pending, full or duplicate.
// - Retry delayed read initiator for queue, order, duplicate or discard reasons.
// - Retry posted write initiator without room for address plus 8 Dwords.
// - Retried initiator must repeat within master timeout, else request dropped.
// - Disconnect initiator at boundary, when write full, or read data exhausted.
// - Every target abort to an initiator sets its signaled-target-abort flag.
// - No device select within five clocks of frame means master abort.
module bth_term_handler #(
  parameter logic [24:0] ATTEMPT_LIMIT = `BTH_ATTEMPT_LIMIT
) (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  // AHB-Lite slave
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic                      hreadyout,
  output logic                      hresp,
  output logic [31:0]               hrdata,
  // Bridge direction, high when the initiator sits on the primary bus
  input  wire logic                 downstream,
  // Target-bus side
  input  wire logic                 txn_start,
  input  wire bth_pkg::txn_type     txn_in,
  input  wire logic                 frame_start,
  input  wire logic                 devsel_seen,
  input  wire bth_pkg::term_in_type term_in,
  output bth_pkg::reissue_type      reissue,
  output logic                      discard,
  // Initiator-bus side
  input  wire logic                 init_req,
  input  wire bth_pkg::kind_type    init_kind,
  input  wire bth_pkg::cond_type    cond,
  input  wire logic                 master_timeout,
  output bth_pkg::resp_out_type     init_resp,
  // System error
  output logic                      primary_system_error_out
);

  typedef struct packed {
    bth_pkg::fsm_type      fsm;
    bth_pkg::txn_type      txn;
    logic [23:0]           cnt;
    logic [2:0]            ma_cnt;
    logic                  ma_arm;
    bth_pkg::resp_type     cmpl;
    bth_pkg::resp_out_type resp;
    bth_pkg::reissue_type  reissue;
    logic                  discard;
    logic                  serr;
    logic [4:0]            ctrl;
    logic [4:0]            status;
    logic                  ap_wr;
    logic [3:0]            ap_ofs;
    logic [31:0]           hrdata;
  } bth_state_type;

  bth_state_type st_ff;
  bth_state_type nxt_st;

  // Set wins over a same-cycle software clear.
  function automatic logic [4:0] sticky(input logic [4:0] cur, input logic [4:0] set,
                                        input logic [4:0] clr);
    sticky = (cur & ~clr) | set;
  endfunction : sticky

  // True when this retried attempt is the last one allowed.
  function automatic logic limit_hit(input logic [23:0] cnt);
    limit_hit = ({1'b0, cnt} + 25'h0000001) >= ATTEMPT_LIMIT;
  endfunction : limit_hit

  function automatic logic [31:0] read_reg(input logic [3:0] ofs, input bth_state_type s);
    unique case (ofs)
      `BTH_CTRL_OFS:    read_reg = {27'h0000000, s.ctrl};
      `BTH_STATUS_OFS:  read_reg = {27'h0000000, s.status};
      `BTH_ATTEMPT_OFS: read_reg = {8'h00, s.cnt};
      default:          read_reg = 32'h00000000;
    endcase
  endfunction : read_reg

  logic [4:0] st_set;
  logic [4:0] st_clr;
  logic       serr_dis;
  logic       retry_end;
  logic       term_ev;
  bth_pkg::term_type term_code;

  always_comb begin
    nxt_st = st_ff;
    st_set = 5'h00;
    st_clr = 5'h00;
    nxt_st.resp.valid = 1'b0;
    nxt_st.reissue.valid = 1'b0;
    nxt_st.discard = 1'b0;
    nxt_st.serr = 1'b0;
    retry_end = 1'b0;
    unique case (st_ff.txn.kind)
      bth_pkg::KIND_DW: serr_dis = st_ff.ctrl[`BTH_CTRL_DIS_DW];
      bth_pkg::KIND_PW: serr_dis = st_ff.ctrl[`BTH_CTRL_DIS_PW];
      default:          serr_dis = st_ff.ctrl[`BTH_CTRL_DIS_DR];
    endcase

    // The slave never stalls, so the address phase is taken whenever hready is high.
    if (hsel && htrans[1] && hready) begin
      nxt_st.ap_wr = hwrite;
      nxt_st.ap_ofs = haddr[3:0];
      nxt_st.hrdata = read_reg(haddr[3:0], st_ff);
    end else begin
      nxt_st.ap_wr = 1'b0;
    end
    if (st_ff.ap_wr) begin
      if (st_ff.ap_ofs == `BTH_CTRL_OFS) begin
        nxt_st.ctrl = hwdata[4:0];
      end
      if (st_ff.ap_ofs == `BTH_STATUS_OFS) begin
        st_clr = hwdata[4:0];
      end
    end

    term_ev = term_in.valid;
    term_code = term_in.code;
    if (frame_start) begin
      nxt_st.ma_arm = 1'b1;
      nxt_st.ma_cnt = 3'h0;
    end else if (st_ff.ma_arm) begin
      if (devsel_seen || term_in.valid) begin
        nxt_st.ma_arm = 1'b0;
      end else if (st_ff.ma_cnt + 3'h1 == `BTH_DEVSEL_WAIT) begin
        nxt_st.ma_arm = 1'b0;
        term_ev = 1'b1;
        term_code = bth_pkg::T_MABORT;
      end else begin
        nxt_st.ma_cnt = st_ff.ma_cnt + 3'h1;
      end
    end

    if (txn_start) begin
      nxt_st.fsm = bth_pkg::S_ACTIVE;
      nxt_st.txn = txn_in;
      nxt_st.cnt = 24'h000000;
      nxt_st.ma_arm = 1'b0;
    end else if (st_ff.fsm == bth_pkg::S_ACTIVE && term_ev) begin
      unique case (term_code)
        bth_pkg::T_NORMAL: begin
          nxt_st.fsm = bth_pkg::S_DONE;
          unique case (st_ff.txn.kind)
            bth_pkg::KIND_DW: nxt_st.cmpl = st_ff.txn.multi ? bth_pkg::R_DISC : bth_pkg::R_TRDY;
            bth_pkg::KIND_PW: nxt_st.fsm = bth_pkg::S_IDLE;
            default: nxt_st.cmpl = (!st_ff.txn.prefetch || term_in.more_req) ?
                                   bth_pkg::R_DISC : bth_pkg::R_TRDY;
          endcase
        end
        bth_pkg::T_RETRY: begin
          retry_end = 1'b1;
        end
        bth_pkg::T_DISC: begin
          if (st_ff.txn.kind == bth_pkg::KIND_PW) begin
            nxt_st.txn.addr = st_ff.txn.addr + {22'h000000, term_in.dwords, 2'b00};
            if (term_in.xfer) begin
              nxt_st.txn.mwi = 1'b0;
            end
            retry_end = 1'b1;
          end else if (!term_in.xfer) begin
            retry_end = 1'b1;
          end else begin
            nxt_st.fsm = bth_pkg::S_DONE;
            if (st_ff.txn.kind == bth_pkg::KIND_DW) begin
              nxt_st.cmpl = st_ff.txn.multi ? bth_pkg::R_DISC : bth_pkg::R_TRDY;
            end else begin
              nxt_st.cmpl = term_in.more_req ? bth_pkg::R_DISC : bth_pkg::R_TRDY;
            end
          end
        end
        bth_pkg::T_TABORT: begin
          st_set[downstream ? `BTH_ST_RCV_TA_SEC : `BTH_ST_RCV_TA_PRI] = 1'b1;
          if (st_ff.txn.kind == bth_pkg::KIND_PW) begin
            nxt_st.fsm = bth_pkg::S_IDLE;
            nxt_st.discard = 1'b1;
            if (st_ff.ctrl[`BTH_CTRL_SERR_EN]) begin
              nxt_st.serr = 1'b1;
              st_set[`BTH_ST_SIG_SERR] = 1'b1;
            end
          end else begin
            nxt_st.fsm = bth_pkg::S_DONE;
            nxt_st.cmpl = bth_pkg::R_TABORT;
          end
        end
        default: begin
          if (st_ff.txn.kind == bth_pkg::KIND_PW) begin
            nxt_st.fsm = bth_pkg::S_IDLE;
            nxt_st.discard = 1'b1;
            if (st_ff.ctrl[`BTH_CTRL_SERR_EN] && st_ff.ctrl[`BTH_CTRL_MA_MODE]) begin
              nxt_st.serr = 1'b1;
              st_set[`BTH_ST_SIG_SERR] = 1'b1;
            end
          end else begin
            nxt_st.fsm = bth_pkg::S_DONE;
            nxt_st.cmpl = st_ff.ctrl[`BTH_CTRL_MA_MODE] ? bth_pkg::R_TABORT : bth_pkg::R_TRDY;
          end
        end
      endcase

      if (retry_end) begin
        if (limit_hit(st_ff.cnt)) begin
          nxt_st.discard = 1'b1;
          nxt_st.fsm = (st_ff.txn.kind == bth_pkg::KIND_PW) ? bth_pkg::S_IDLE :
                       bth_pkg::S_EXHAUSTED;
          if (st_ff.ctrl[`BTH_CTRL_SERR_EN] && !serr_dis) begin
            nxt_st.serr = 1'b1;
            st_set[`BTH_ST_SIG_SERR] = 1'b1;
          end
        end else begin
          nxt_st.cnt = st_ff.cnt + 24'h000001;
          nxt_st.reissue.valid = 1'b1;
          nxt_st.reissue.addr = nxt_st.txn.addr;
          nxt_st.reissue.plain_write = !nxt_st.txn.mwi;
        end
      end
    end

    if (master_timeout && !txn_start && st_ff.fsm != bth_pkg::S_IDLE &&
        st_ff.txn.kind != bth_pkg::KIND_PW) begin
      nxt_st.fsm = bth_pkg::S_IDLE;
      nxt_st.discard = 1'b1;
    end

    // Initiator-side answer, one pulse per request.
    if (init_req) begin
      nxt_st.resp.valid = 1'b1;
      nxt_st.resp.code = bth_pkg::R_TRDY;
      if (init_kind == bth_pkg::KIND_PW) begin
        // room for address plus 8 Dwords
        if (cond.pw_space < `BTH_PW_MIN_DW) begin
          nxt_st.resp.code = bth_pkg::R_RETRY;
        end else if (cond.boundary || cond.no_space) begin
          nxt_st.resp.code = bth_pkg::R_DISC;
        end
      end else if (st_ff.fsm == bth_pkg::S_EXHAUSTED && st_ff.txn.kind == init_kind) begin
        nxt_st.resp.code = bth_pkg::R_TABORT;
        nxt_st.fsm = bth_pkg::S_IDLE;
      end else if (cond.queuing || cond.pending || cond.not_head || cond.q_full ||
                   cond.dup || (init_kind == bth_pkg::KIND_DR &&
                   (cond.pw_ahead || cond.discarding))) begin
        nxt_st.resp.code = bth_pkg::R_RETRY;
      end else if (st_ff.fsm == bth_pkg::S_DONE && st_ff.txn.kind == init_kind) begin
        nxt_st.resp.code = st_ff.cmpl;
        nxt_st.fsm = bth_pkg::S_IDLE;
        if (st_ff.cmpl == bth_pkg::R_TRDY && (cond.boundary || cond.no_read)) begin
          nxt_st.resp.code = bth_pkg::R_DISC;
        end
      end else begin
        nxt_st.resp.code = bth_pkg::R_RETRY;
      end
      if (nxt_st.resp.code == bth_pkg::R_TABORT) begin
        st_set[downstream ? `BTH_ST_SIG_TA_PRI : `BTH_ST_SIG_TA_SEC] = 1'b1;
      end
    end

    nxt_st.status = sticky(st_ff.status, st_set, st_clr);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Writes land in one cycle, so the slave is always ready and always OKAY.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = st_ff.hrdata;
  assign reissue = st_ff.reissue;
  assign discard = st_ff.discard;
  assign init_resp = st_ff.resp;
  assign primary_system_error_out = st_ff.serr;

endmodule : bth_term_handler

// ### verification/bth_term_handler_props.sv
`timescale 1ns/1ps
module bth_term_handler_props #(
  parameter logic [24:0] ATTEMPT_LIMIT = 25'h1000000
) (
  // Clock and reset
  input wire logic                  clk,
  input wire logic                  rst,
  // Watched ports
  input wire logic                  hreadyout,
  input wire logic                  hresp,
  input wire logic                  txn_start,
  input wire bth_pkg::term_in_type  term_in,
  input wire bth_pkg::reissue_type  reissue,
  input wire logic                  discard,
  input wire logic                  init_req,
  input wire bth_pkg::kind_type     init_kind,
  input wire bth_pkg::cond_type     cond,
  input wire bth_pkg::resp_out_type init_resp
);
  logic [24:0] cnt_ff;
  logic [24:0] nxt_cnt;

  default clocking dc @(posedge clk); endclocking
  default disable iff (rst);

  // Counts target retries of the current transaction only.
  always_comb begin
    nxt_cnt = cnt_ff;
    if (txn_start)
      nxt_cnt = 25'h0;
    else if (term_in.valid && term_in.code == bth_pkg::T_RETRY)
      nxt_cnt = cnt_ff + 25'h1;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      cnt_ff <= 25'h0;
    else
      cnt_ff <= nxt_cnt;
  end

  sequence s_retry;
    term_in.valid && term_in.code == bth_pkg::T_RETRY;
  endsequence
  sequence s_abort;
    term_in.valid && term_in.code == bth_pkg::T_TABORT;
  endsequence
  sequence s_normal;
    term_in.valid && term_in.code == bth_pkg::T_NORMAL;
  endsequence

  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus slave not ready or not okay");
  chk_resp_cause: assert property (init_resp.valid |-> $past(init_req))
    else $error("initiator answer without a request");
  chk_pw_room: assert property (
    init_req && init_kind == bth_pkg::KIND_PW && cond.pw_space < 5'h08
    |=> init_resp.valid && init_resp.code == bth_pkg::R_RETRY)
    else $error("posted write without room not retried");
  chk_dw_busy: assert property (
    init_req && init_kind == bth_pkg::KIND_DW && (cond.q_full || cond.dup || cond.queuing)
    |=> init_resp.valid && init_resp.code == bth_pkg::R_RETRY)
    else $error("busy delayed write not retried");
  chk_dr_busy: assert property (
    init_req && init_kind == bth_pkg::KIND_DR && (cond.pw_ahead || cond.discarding)
    |=> init_resp.valid && init_resp.code == bth_pkg::R_RETRY)
    else $error("busy delayed read not retried");
  chk_reissue_cause: assert property (
    reissue.valid |-> $past(term_in.valid)
    && $past(term_in.code) inside {bth_pkg::T_RETRY, bth_pkg::T_DISC})
    else $error("reissue without retry or disconnect");
  chk_abort_halt: assert property (s_abort |=> !reissue.valid)
    else $error("reissue after target abort");
  chk_normal_quiet: assert property (s_normal |=> !reissue.valid && !discard)
    else $error("action after normal termination");
  chk_limit_drop: assert property (
    s_retry ##0 (cnt_ff == ATTEMPT_LIMIT - 25'h1) |=> discard)
    else $error("request not dropped at attempt limit");
endmodule : bth_term_handler_props

bind bth_term_handler bth_term_handler_props #(.ATTEMPT_LIMIT(ATTEMPT_LIMIT)) u_props (
  .clk(clk), .rst(rst), .hreadyout(hreadyout), .hresp(hresp), .txn_start(txn_start),
  .term_in(term_in), .reissue(reissue), .discard(discard), .init_req(init_req),
  .init_kind(init_kind), .cond(cond), .init_resp(init_resp));

// ### verification/bth_target_model.sv
`timescale 1ns/1ps
module bth_target_model (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  // Bridge frame and planned ending
  input  wire logic                 frame_start,
  input  wire bth_pkg::term_in_type plan,
  input  wire logic [3:0]           lag,
  // Target answer
  output logic                      devsel_seen,
  output bth_pkg::term_in_type      term_in
);
  logic [3:0]           wait_ff;
  bth_pkg::term_in_type hold_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wait_ff     <= 4'h0;
      hold_ff     <= '0;
      devsel_seen <= 1'b0;
      term_in     <= '0;
    end else begin
      if (frame_start) begin
        wait_ff <= lag;
        hold_ff <= plan;
      end else if (wait_ff != 4'h0) begin
        wait_ff <= wait_ff - 4'h1;
      end
      // Idle fields show inverted data so a stale ending never looks valid by luck.
      if (!frame_start && wait_ff == 4'h1) begin
        devsel_seen <= 1'b1;
        term_in     <= hold_ff;
      end else begin
        devsel_seen <= 1'b0;
        term_in     <= {1'b0, ~hold_ff[12:0]};
      end
    end
  end
endmodule : bth_target_model

// ### verification/bth_term_handler_bench.sv
`timescale 1ns/1ps
module bth_term_handler_bench;
  logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic txn_start = 1'b0, frame_start = 1'b0, init_req = 1'b0;
  logic hreadyout, hresp, devsel_seen, discard, serr;
  logic [1:0] htrans = 2'h0;
  logic [3:0] lag = 4'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, d;
  bth_pkg::txn_type txn_in = '0;
  bth_pkg::term_in_type plan = '0, term_in;
  bth_pkg::reissue_type reissue;
  bth_pkg::kind_type init_kind = bth_pkg::KIND_DW;
  bth_pkg::cond_type cond = '0;
  bth_pkg::resp_out_type init_resp;
  int miscompares = 0, compares = 0, cyc = 0;
  logic req_multi = 1'b1, req_pref = 1'b0, req_more = 1'b0, dn = 1'b1, mto = 1'b0;

  always #25 clk = ~clk;

  bth_term_handler #(.ATTEMPT_LIMIT(25'h4)) uut (
    .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .downstream(dn), .txn_start(txn_start),
    .txn_in(txn_in), .frame_start(frame_start), .devsel_seen(devsel_seen),
    .term_in(term_in), .reissue(reissue), .discard(discard), .init_req(init_req),
    .init_kind(init_kind), .cond(cond), .master_timeout(mto), .init_resp(init_resp),
    .primary_system_error_out(serr));

  bth_target_model far_end (
    .clk(clk), .rst(rst), .frame_start(frame_start), .plan(plan), .lag(lag),
    .devsel_seen(devsel_seen), .term_in(term_in));

  task automatic close_out();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : close_out

  task automatic check(input string what, input logic [39:0] e, input logic [39:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask : check

  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    d = hrdata;
  endtask : ahb

  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    check($sformatf("reg %0h", a), {8'h0, e}, {8'h0, d});
  endtask : rd

  task automatic start(input bth_pkg::kind_type k, input logic [31:0] a, input logic m);
    @(posedge clk);
    txn_start <= 1'b1;
    txn_in    <= '{kind: k, multi: req_multi, prefetch: req_pref, mwi: m, addr: a};
    @(posedge clk);
    txn_start <= 1'b0;
  endtask : start

  // Returns just after the edge that takes the target's ending.
  task automatic attempt(input bth_pkg::term_type c, input logic [7:0] dw);
    int n;
    n = 0;
    @(posedge clk);
    frame_start <= 1'b1;
    plan <= '{valid: 1'b1, code: c, xfer: dw != 8'h0, dwords: dw, more_req: req_more};
    @(posedge clk);
    frame_start <= 1'b0;
    do begin
      @(posedge clk);
      n++;
    end while (term_in.valid !== 1'b1 && n < 20);
    #1;
  endtask : attempt

  task automatic ask(input bth_pkg::kind_type k, input bth_pkg::cond_type c,
                     input bth_pkg::resp_type e);
    @(posedge clk);
    init_req  <= 1'b1;
    init_kind <= k;
    cond      <= c;
    @(posedge clk);
    init_req <= 1'b0;
    #1;
    check("init_resp", {37'h0, 1'b1, e}, {37'h0, init_resp});
  endtask : ask

  task automatic regs();
    rd(32'h0, 32'h0);
    rd(32'h4, 32'h0);
    rd(32'h8, 32'h0);
    ahb(1'b1, 32'hc, 32'hff);
    rd(32'hc, 32'h0);
    ahb(1'b1, 32'h0, 32'h1);
    rd(32'h0, 32'h1);
  endtask : regs

  // A finished completion waits, so only the condition can turn the answer into retry.
  task automatic conds();
    start(bth_pkg::KIND_DR, 32'h6000, 1'b0);
    attempt(bth_pkg::T_NORMAL, 8'h1);
    for (int i = 8; i < 15; i++)
      ask(bth_pkg::KIND_DR, 15'h0040 | (15'h1 << i), bth_pkg::R_RETRY);
    ask(bth_pkg::KIND_DR, '0, bth_pkg::R_DISC);
    start(bth_pkg::KIND_DW, 32'h7000, 1'b0);
    attempt(bth_pkg::T_NORMAL, 8'h1);
    for (int i = 10; i < 15; i++)
      ask(bth_pkg::KIND_DW, 15'h0040 | (15'h1 << i), bth_pkg::R_RETRY);
    ask(bth_pkg::KIND_DW, '0, bth_pkg::R_DISC);
    ask(bth_pkg::KIND_PW, 15'h0038, bth_pkg::R_RETRY);
    ask(bth_pkg::KIND_PW, 15'h0040, bth_pkg::R_TRDY);
    ask(bth_pkg::KIND_PW, 15'h0044, bth_pkg::R_DISC);
  endtask : conds

  task automatic posted();
    start(bth_pkg::KIND_PW, 32'h1000, 1'b1);
    attempt(bth_pkg::T_RETRY, 8'h0);
    check("reissue", {6'h0, 1'b1, 32'h1000, 1'b0}, {6'h0, reissue});
    attempt(bth_pkg::T_DISC, 8'h2);
    check("reissue", {6'h0, 1'b1, 32'h1008, 1'b1}, {6'h0, reissue});
    attempt(bth_pkg::T_NORMAL, 8'h1);
    check("reissue or drop", 40'h0, {39'h0, reissue.valid | discard});
    start(bth_pkg::KIND_PW, 32'h1100, 1'b0);
    attempt(bth_pkg::T_TABORT, 8'h0);
    check("serr", 40'h1, {39'h0, serr});
    rd(32'h4, 32'h12);
    ahb(1'b1, 32'h4, 32'h1f);
    rd(32'h4, 32'h0);
  endtask : posted

  task automatic limit();
    lag <= 4'h4;
    start(bth_pkg::KIND_DW, 32'h2000, 1'b0);
    for (int i = 0; i < 3; i++) begin
      attempt(bth_pkg::T_RETRY, 8'h0);
      check("reissue valid", 40'h1, {39'h0, reissue.valid});
      ask(bth_pkg::KIND_DW, '0, bth_pkg::R_RETRY);
    end
    rd(32'h8, 32'h3);
    attempt(bth_pkg::T_RETRY, 8'h0);
    check("drop and serr", 40'h3, {38'h0, discard, serr});
    ask(bth_pkg::KIND_DW, '0, bth_pkg::R_TABORT);
    ahb(1'b0, 32'h4, 32'h0);
    check("status", 40'h4, {36'h0, d[3:0]});
    ahb(1'b1, 32'h4, 32'h1f);
  endtask : limit

  task automatic delayed();
    lag <= 4'h1;
    start(bth_pkg::KIND_DR, 32'h3000, 1'b0);
    attempt(bth_pkg::T_TABORT, 8'h0);
    check("reissue valid", 40'h0, {39'h0, reissue.valid});
    ask(bth_pkg::KIND_DR, '0, bth_pkg::R_TABORT);
    rd(32'h4, 32'h6);
    ahb(1'b1, 32'h4, 32'h1f);
    start(bth_pkg::KIND_DW, 32'h4000, 1'b0);
    attempt(bth_pkg::T_NORMAL, 8'h1);
    ask(bth_pkg::KIND_DW, '0, bth_pkg::R_DISC);
    start(bth_pkg::KIND_DR, 32'h5000, 1'b0);
    attempt(bth_pkg::T_NORMAL, 8'h1);
    ask(bth_pkg::KIND_DR, '0, bth_pkg::R_DISC);
  endtask : delayed

  task automatic corners();
    req_multi = 1'b0;
    start(bth_pkg::KIND_DW, 32'h8000, 1'b0);
    attempt(bth_pkg::T_DISC, 8'h1);
    ask(bth_pkg::KIND_DW, '0, bth_pkg::R_TRDY);
    req_multi = 1'b1;
    req_pref = 1'b1;
    start(bth_pkg::KIND_DR, 32'h9000, 1'b0);
    attempt(bth_pkg::T_NORMAL, 8'h1);
    ask(bth_pkg::KIND_DR, '0, bth_pkg::R_TRDY);
    start(bth_pkg::KIND_DR, 32'h9100, 1'b0);
    attempt(bth_pkg::T_NORMAL, 8'h1);
    ask(bth_pkg::KIND_DR, 15'h0001, bth_pkg::R_DISC);
    req_more = 1'b1;
    start(bth_pkg::KIND_DR, 32'h9200, 1'b0);
    attempt(bth_pkg::T_DISC, 8'h1);
    ask(bth_pkg::KIND_DR, '0, bth_pkg::R_DISC);
    req_more = 1'b0;
    req_pref = 1'b0;
    // Master abort: the target never claims, the watchdog ends the attempt.
    ahb(1'b1, 32'h0, 32'h3);
    lag <= 4'h0;
    start(bth_pkg::KIND_PW, 32'ha000, 1'b0);
    @(posedge clk);
    frame_start <= 1'b1;
    @(posedge clk);
    frame_start <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    check("early drop", 40'h0, {39'h0, discard});
    @(posedge clk);
    #1;
    check("abort drop", 40'h3, {38'h0, discard, serr});
    start(bth_pkg::KIND_DR, 32'ha100, 1'b0);
    attempt(bth_pkg::T_NORMAL, 8'h0);
    ask(bth_pkg::KIND_DR, '0, bth_pkg::R_TABORT);
    lag <= 4'h2;
    ahb(1'b1, 32'h0, 32'h1);
    ahb(1'b1, 32'h4, 32'h1f);
    dn <= 1'b0;
    start(bth_pkg::KIND_DW, 32'hb000, 1'b0);
    attempt(bth_pkg::T_TABORT, 8'h0);
    ask(bth_pkg::KIND_DW, '0, bth_pkg::R_TABORT);
    rd(32'h4, 32'h9);
    dn <= 1'b1;
    ahb(1'b1, 32'h4, 32'h1f);
    start(bth_pkg::KIND_DW, 32'hc000, 1'b0);
    attempt(bth_pkg::T_NORMAL, 8'h1);
    @(posedge clk);
    mto <= 1'b1;
    @(posedge clk);
    mto <= 1'b0;
    #1;
    check("timeout drop", 40'h1, {39'h0, discard});
    ask(bth_pkg::KIND_DW, '0, bth_pkg::R_RETRY);
    ahb(1'b1, 32'h0, 32'h9);
    start(bth_pkg::KIND_PW, 32'hd000, 1'b0);
    repeat (3) attempt(bth_pkg::T_RETRY, 8'h0);
    attempt(bth_pkg::T_RETRY, 8'h0);
    check("posted drop", 40'h2, {38'h0, discard, serr});
    ahb(1'b1, 32'h0, 32'h1);
  endtask : corners

  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      close_out();
    end
  end

  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    regs();
    conds();
    posted();
    limit();
    delayed();
    corners();
    close_out();
  end
endmodule : bth_term_handler_bench
